// File: acm_device.sv
// Purpose: Converter end: mode selection, serial registers, output ordering
// Assumes: Link pins asynchronous to pclk; sample_strobe on pclk
// Notes: Long reset-high means pin-only mode; shorter high is an init pulse
`default_nettype none
module acm_device #(
	parameter int WIDTH = 12,
	parameter int PIN_HOLD = acm_pkg::ACM_PIN_HOLD_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	acm_link_if.device link,
	input wire logic sample_strobe,
	input wire logic [WIDTH-1:0] sample_a,
	input wire logic [WIDTH-1:0] sample_b,
	output logic [WIDTH-1:0] dout_a,
	output logic [WIDTH-1:0] dout_b,
	output logic dout_oe_a,
	output logic dout_oe_b,
	output logic ddr_phase,
	output logic pin_mode,
	output logic cfg_gain,
	output logic cfg_extref,
	output logic cfg_cmos,
	output logic cfg_sbin,
	output logic [2:0] cfg_code
);
	// ==========================================
	// Synchronisers
	logic [10:0] s1_r, s2_r, s1_nxt;
	logic rst_s, sen_s, sclk_s, sdat_s;
	logic [1:0] senl_s, sclkl_s;
	logic [2:0] pins_s;
	always_comb begin
		s1_nxt = {link.reset_pin, link.serial_enable, link.serial_clock, link.config_serial_input,
			link.sen_level, link.sclk_level, link.mode_pin_1, link.mode_pin_2, link.mode_pin_3};
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= 11'h000;
			s2_r <= 11'h000;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s1_r;
		end
	end
	assign {rst_s, sen_s, sclk_s, sdat_s, senl_s, sclkl_s, pins_s} = s2_r;

	// ==========================================
	// Mode detection and serial registers
	logic [$clog2(PIN_HOLD+1)-1:0] hold_r, hold_nxt;
	logic sclk_prev_r, sclk_prev_nxt;
	logic [15:0] sh_r, sh_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [2:0] pd_r, pd_nxt;
	logic pin_priority_override_r, pin_priority_override_nxt;
	logic [3:0] cfg_r, cfg_nxt;
	logic pin_mode_now;
	always_comb begin
		hold_nxt = hold_r;
		sclk_prev_nxt = sclk_s;
		sh_nxt = sh_r;
		bit_nxt = bit_r;
		pd_nxt = pd_r;
		pin_priority_override_nxt = pin_priority_override_r;
		cfg_nxt = cfg_r;
		pin_mode_now = (32'(hold_r) == PIN_HOLD);
		if (!rst_s) begin
			hold_nxt = '0;
		end else if (!pin_mode_now) begin
			hold_nxt = hold_r + 1'b1;
		end
		if (rst_s) begin
			// Registers held at defaults while the pin is high
			pd_nxt = acm_pkg::ACM_PD_RST;
			pin_priority_override_nxt = 1'b0;
			cfg_nxt = acm_pkg::ACM_CFG_RST;
			bit_nxt = 4'h0;
		end else if (sen_s) begin
			bit_nxt = 4'h0;
		end else if (sclk_prev_r && !sclk_s) begin
			sh_nxt = {sh_r[14:0], sdat_s};
			bit_nxt = bit_r + 4'h1;
			if (bit_r == 4'(acm_pkg::ACM_WORD_BITS - 1)) begin
				unique case (sh_r[14:7])
					acm_pkg::ACM_SREG_INIT: begin
						if (sh_nxt[acm_pkg::ACM_INIT_BIT]) begin
							// Bit is never stored, so it reads back low
							pd_nxt = acm_pkg::ACM_PD_RST;
							pin_priority_override_nxt = 1'b0;
							cfg_nxt = acm_pkg::ACM_CFG_RST;
						end
					end
					acm_pkg::ACM_SREG_PD: begin
						pd_nxt = sh_nxt[2:0];
						pin_priority_override_nxt = sh_nxt[acm_pkg::ACM_PIN_PRIORITY_OVERRIDE_BIT];
					end
					acm_pkg::ACM_SREG_CFG: cfg_nxt = sh_nxt[3:0];
					default: ;
				endcase
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_r <= '0;
			sclk_prev_r <= 1'b0;
			sh_r <= 16'h0000;
			bit_r <= 4'h0;
			pd_r <= acm_pkg::ACM_PD_RST;
			pin_priority_override_r <= 1'b0;
			cfg_r <= acm_pkg::ACM_CFG_RST;
		end else begin
			hold_r <= hold_nxt;
			sclk_prev_r <= sclk_prev_nxt;
			sh_r <= sh_nxt;
			bit_r <= bit_nxt;
			pd_r <= pd_nxt;
			pin_priority_override_r <= pin_priority_override_nxt;
			cfg_r <= cfg_nxt;
		end
	end

	// ==========================================
	// Effective configuration
	logic pm_nxt, gain_nxt, ext_nxt, cmos_nxt, sbin_nxt;
	logic [2:0] code_nxt;
	always_comb begin
		pm_nxt = pin_mode_now;
		if (pin_mode_now) begin
			gain_nxt = sclkl_s[1];
			ext_nxt = sclkl_s[1] ^ sclkl_s[0];
			cmos_nxt = senl_s[1];
			sbin_nxt = senl_s[1] ^ senl_s[0];
			code_nxt = pins_s;
		end else begin
			// Analog levels ignored here
			gain_nxt = cfg_r[acm_pkg::ACM_GAIN_BIT];
			ext_nxt = cfg_r[acm_pkg::ACM_EXTREF_BIT];
			cmos_nxt = cfg_r[acm_pkg::ACM_CMOS_BIT];
			sbin_nxt = cfg_r[acm_pkg::ACM_SBIN_BIT];
			// Power-down source picked by override
			code_nxt = pin_priority_override_r ? pd_r : pins_s;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_mode <= 1'b0;
			cfg_gain <= 1'b0;
			cfg_extref <= 1'b0;
			cfg_cmos <= 1'b0;
			cfg_sbin <= 1'b0;
			cfg_code <= 3'h0;
		end else begin
			pin_mode <= pm_nxt;
			cfg_gain <= gain_nxt;
			cfg_extref <= ext_nxt;
			cfg_cmos <= cmos_nxt;
			cfg_sbin <= sbin_nxt;
			cfg_code <= code_nxt;
		end
	end

	// ==========================================
	// Latency pipeline and output ordering
	localparam int ACM_LAT = acm_pkg::ACM_LATENCY;
	logic [WIDTH-1:0] pa_r [ACM_LAT], pb_r [ACM_LAT];
	genvar gi;
	generate
		for (gi = 0; gi < ACM_LAT; gi++) begin : g_pipe
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pa_r[gi] <= '0;
					pb_r[gi] <= '0;
				end else if (sample_strobe) begin
					pa_r[gi] <= (gi == 0) ? sample_a : pa_r[gi == 0 ? 0 : gi-1];
					pb_r[gi] <= (gi == 0) ? sample_b : pb_r[gi == 0 ? 0 : gi-1];
				end
			end
		end
	endgenerate

	function automatic logic [WIDTH-1:0] acm_fmt(input logic [WIDTH-1:0] v, input logic sbin);
		acm_fmt = sbin ? {~v[WIDTH-1], v[WIDTH-2:0]} : v;
	endfunction
	function automatic logic [WIDTH-1:0] acm_lanes(input logic [WIDTH-1:0] v, input logic odd);
		acm_lanes = '0;
		for (int i = 0; i < WIDTH / 2; i++) begin
			acm_lanes[i] = v[2*i + (odd ? 1 : 0)];
		end
	endfunction

	logic [WIDTH-1:0] da_nxt, db_nxt, fa, fb;
	logic oea_nxt, oeb_nxt, ph_nxt, mux;
	always_comb begin
		fa = acm_fmt(pa_r[ACM_LAT-1], cfg_sbin);
		fb = acm_fmt(pb_r[ACM_LAT-1], cfg_sbin);
		ph_nxt = ~ddr_phase;
		mux = (cfg_code == acm_pkg::ACM_CODE_MUX) && cfg_cmos;
		oea_nxt = 1'b1;
		oeb_nxt = 1'b1;
		unique case (cfg_code)
			acm_pkg::ACM_CODE_A_BUF_OFF, acm_pkg::ACM_CODE_A_STBY: oea_nxt = 1'b0;
			acm_pkg::ACM_CODE_B_BUF_OFF, acm_pkg::ACM_CODE_B_STBY: oeb_nxt = 1'b0;
			acm_pkg::ACM_CODE_AB_BUF_OFF, acm_pkg::ACM_CODE_AB_PD: begin
				oea_nxt = 1'b0;
				oeb_nxt = 1'b0;
			end
			acm_pkg::ACM_CODE_MUX: oeb_nxt = !cfg_cmos;
			default: ;
		endcase
		if (mux) begin
			da_nxt = ph_nxt ? fb : fa;
			db_nxt = '0;
		end else if (cfg_cmos) begin
			da_nxt = fa;
			db_nxt = fb;
		end else begin
			da_nxt = acm_lanes(fa, ph_nxt);
			db_nxt = acm_lanes(fb, ph_nxt);
		end
		if (!oea_nxt) begin
			da_nxt = '0;
		end
		if (!oeb_nxt) begin
			db_nxt = '0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout_a <= '0;
			dout_b <= '0;
			dout_oe_a <= 1'b0;
			dout_oe_b <= 1'b0;
			ddr_phase <= 1'b0;
		end else begin
			dout_a <= da_nxt;
			dout_b <= db_nxt;
			dout_oe_a <= oea_nxt;
			dout_oe_b <= oeb_nxt;
			ddr_phase <= ph_nxt;
		end
	end
endmodule
`default_nettype wire

// File: acm_host.sv
// Purpose: Host end: APB registers drive the converter's configuration pins
// Assumes: Software picks the scheme and issues 16-bit serial writes
// Notes: Serial clock made here by a divider, so no second domain
`default_nettype none
module acm_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	acm_link_if.host link
);
	typedef enum logic [2:0] {ACM_IDLE, ACM_PULSE, ACM_SETUP, ACM_SHIFT, ACM_HOLD} acm_state_e;
	// ==========================================
	// Registers and sequencer
	acm_state_e st_r, st_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic [7:0] pins_r, pins_nxt;
	logic [15:0] word_r, word_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [3:0] div_r, div_nxt;
	logic rst_r, rst_nxt, sen_r, sen_nxt, sck_r, sck_nxt, sd_r, sd_nxt;
	logic [31:0] rd_nxt;
	logic rdy_nxt, err_nxt, wr, busy;
	always_comb begin
		st_nxt = st_r;
		mode_nxt = mode_r;
		pins_nxt = pins_r;
		word_nxt = word_r;
		cnt_nxt = cnt_r;
		div_nxt = div_r;
		sck_nxt = sck_r;
		sd_nxt = sd_r;
		sen_nxt = sen_r;
		busy = (st_r != ACM_IDLE);
		rdy_nxt = psel && penable && !pready;
		wr = rdy_nxt && pwrite;
		err_nxt = 1'b0;
		rd_nxt = 32'h0000_0000;
		if (rdy_nxt) begin
			unique case (paddr)
				acm_pkg::ACM_A_CTRL: rd_nxt = {30'h0, mode_r};
				acm_pkg::ACM_A_PINS: rd_nxt = {24'h0, pins_r};
				acm_pkg::ACM_A_WRITE: rd_nxt = {16'h0, word_r};
				acm_pkg::ACM_A_STATUS: rd_nxt = {31'h0, busy};
				default: err_nxt = 1'b1;
			endcase
		end
		// Writes while busy are dropped; poll status first
		if (wr && !busy) begin
			if (paddr == acm_pkg::ACM_A_CTRL) begin
				mode_nxt = pwdata[1:0];
				// Init pulse on the pin before any programming
				if (pwdata[1:0] != 2'(acm_pkg::ACM_MODE_PIN)) begin
					st_nxt = ACM_PULSE;
					cnt_nxt = 5'(acm_pkg::ACM_RST_PULSE_CYC);
				end
			end
			if (paddr == acm_pkg::ACM_A_PINS) begin
				pins_nxt = pwdata[7:0];
			end
			if (paddr == acm_pkg::ACM_A_WRITE && mode_r != 2'(acm_pkg::ACM_MODE_PIN)) begin
				word_nxt = pwdata[15:0];
				st_nxt = ACM_SETUP;
				sen_nxt = 1'b0;
				cnt_nxt = 5'(acm_pkg::ACM_SEN_SETUP_CYC);
			end
		end
		// Pin mode: reset high steady; else low after pulse
		rst_nxt = (mode_nxt == 2'(acm_pkg::ACM_MODE_PIN)) || (st_nxt == ACM_PULSE);
		unique case (st_r)
			ACM_IDLE: ;
			ACM_PULSE, ACM_SETUP, ACM_HOLD: begin
				cnt_nxt = cnt_r - 5'h1;
				if (cnt_r == 5'h0) begin
					st_nxt = ACM_IDLE;
					if (st_r == ACM_SETUP) begin
						st_nxt = ACM_SHIFT;
						cnt_nxt = 5'(acm_pkg::ACM_WORD_BITS);
						div_nxt = 4'h0;
						sd_nxt = word_r[15];
						sck_nxt = 1'b1;
					end
					if (st_r == ACM_HOLD) begin
						sen_nxt = 1'b1;
					end
					rst_nxt = (mode_r == 2'(acm_pkg::ACM_MODE_PIN));
				end
			end
			ACM_SHIFT: begin
				div_nxt = div_r + 4'h1;
				if (div_r == 4'(acm_pkg::ACM_SCLK_HALF_CYC - 1)) begin
					div_nxt = 4'h0;
					sck_nxt = ~sck_r;
					if (sck_r) begin
						// Falling edge: device samples here
						cnt_nxt = cnt_r - 5'h1;
						word_nxt = {word_r[14:0], 1'b0};
					end else if (cnt_r == 5'h0) begin
						st_nxt = ACM_HOLD;
						sck_nxt = sck_r;
						cnt_nxt = 5'(acm_pkg::ACM_SEN_SETUP_CYC);
					end else begin
						sd_nxt = word_r[15];
					end
				end
			end
			default: st_nxt = ACM_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ACM_IDLE;
			mode_r <= 2'(acm_pkg::ACM_MODE_SERIAL);
			pins_r <= 8'h00;
			word_r <= 16'h0000;
			cnt_r <= 5'h00;
			div_r <= 4'h0;
			rst_r <= 1'b0;
			sen_r <= 1'b1;
			sck_r <= 1'b0;
			sd_r <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			st_r <= st_nxt;
			mode_r <= mode_nxt;
			pins_r <= pins_nxt;
			word_r <= word_nxt;
			cnt_r <= cnt_nxt;
			div_r <= div_nxt;
			rst_r <= rst_nxt;
			sen_r <= sen_nxt;
			sck_r <= sck_nxt;
			sd_r <= sd_nxt;
			prdata <= rd_nxt;
			pready <= rdy_nxt;
			pslverr <= err_nxt;
		end
	end

	// ==========================================
	// Pin drive; analog steps driven from pins_r in every mode
	logic pin_md;
	assign pin_md = (mode_r == 2'(acm_pkg::ACM_MODE_PIN));
	assign link.reset_pin = rst_r;
	assign link.serial_enable = pin_md ? pins_r[4] : sen_r;
	assign link.serial_clock = pin_md ? pins_r[6] : sck_r;
	assign link.config_serial_input = sd_r;
	assign link.sen_level = pins_r[4:3];
	assign link.sclk_level = pins_r[6:5];
	// Serial-only grounds the mode pins
	assign link.mode_pin_1 = (mode_r != 2'(acm_pkg::ACM_MODE_SERIAL)) && pins_r[2];
	assign link.mode_pin_2 = (mode_r != 2'(acm_pkg::ACM_MODE_SERIAL)) && pins_r[1];
	assign link.mode_pin_3 = (mode_r != 2'(acm_pkg::ACM_MODE_SERIAL)) && pins_r[0];
endmodule
`default_nettype wire

// File: acm_link_if.sv
// Purpose: Pins between converter and configuring host
// Assumes: Levels on sen_level and sclk_level stand for the four analog steps
// Notes: All signals driven by the host
`default_nettype none
interface acm_link_if;
	logic reset_pin;
	logic serial_enable;
	logic serial_clock;
	logic config_serial_input;
	logic [1:0] sen_level;
	logic [1:0] sclk_level;
	logic mode_pin_1;
	logic mode_pin_2;
	logic mode_pin_3;
	modport host (output reset_pin, serial_enable, serial_clock, config_serial_input, sen_level, sclk_level,
		mode_pin_1, mode_pin_2, mode_pin_3);
	modport device (input reset_pin, serial_enable, serial_clock, config_serial_input, sen_level, sclk_level,
		mode_pin_1, mode_pin_2, mode_pin_3);
endinterface
`default_nettype wire

// File: acm_link_sva.sv
// Purpose: Checks the host's framing of the configuration link
// Assumes: Every link pin is driven by the host on pclk
// Notes: Frames are judged while the reset pin is low, except by a_data_stable, which ignores the reset pin
`default_nettype none
module acm_link_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic reset_pin,
	input wire logic serial_enable,
	input wire logic serial_clock,
	input wire logic config_serial_input
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Falling edges counted per frame, wraps at 16
	logic [3:0] falls_r;
	logic [3:0] falls_nxt;
	logic sclk_r;
	logic sclk_nxt;
	always_comb begin
		falls_nxt = falls_r;
		sclk_nxt = serial_clock;
		if (reset_pin || serial_enable)
			falls_nxt = 4'h0;
		else if (sclk_r && !serial_clock)
			falls_nxt = falls_r + 4'h1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			falls_r <= 4'h0;
			sclk_r <= 1'b0;
		end else begin
			falls_r <= falls_nxt;
			sclk_r <= sclk_nxt;
		end
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_sclk_gated: assert property ($rose(serial_clock) && !reset_pin |-> !serial_enable)
		else $error("serial clock pulsed outside a frame");
	a_sen_setup: assert property ($fell(serial_enable) && !reset_pin |-> !serial_clock [*5])
		else $error("serial clock rose too soon after enable");
	a_sclk_half: assert property ($rose(serial_clock) && !reset_pin |-> serial_clock [*5] ##1 !serial_clock)
		else $error("serial clock high phase not five cycles");
	a_sen_hold: assert property ($rose(serial_enable) && !reset_pin |->
			!$past(serial_clock) && !$past(serial_clock, 2) && !$past(serial_clock, 3) &&
			!$past(serial_clock, 4) && !$past(serial_clock, 5))
		else $error("enable released too soon after last clock");
	a_word_whole: assert property ($rose(serial_enable) && !reset_pin |-> falls_r == 4'h0)
		else $error("frame not a whole number of words");
	a_data_stable: assert property ($fell(serial_clock) && !serial_enable |-> $stable(config_serial_input))
		else $error("serial data moved at a capture edge");
	a_rst_width: assert property ($rose(reset_pin) |-> reset_pin [*4])
		else $error("reset pulse too short");
	a_rst_low: assert property ($fell(reset_pin) |-> !reset_pin [*8])
		else $error("reset pin rose again after init");
endmodule
`default_nettype wire

// File: acm_pkg.sv
// Purpose: Shared constants for the ADC configuration-mode link and its two ends
// Assumes: One 200 MHz clock (pclk) on both ends
// Notes: Summary of operation below
// Summary of operation
// - Pin-only mode: reset pin held high permanently
// - Pin mode configures itself from the pins
// - Pin mode reads enable and clock as levels
// - Clock level picks coarse gain and reference
// - Enable level picks LVDS/CMOS and number format
// - Three mode pins select power-down and mux
// - Serial mode: reset pin held low
// - Serial/mixed mode: three pins form serial port
// - Host restores register defaults before programming
// - Reset pin stays low after initialization
// - Serial-only: host grounds all mode pins
// - Reset low: registers and mode pins both apply
// - Mixed mode applies mode pins from power-up
// - Override zero: power-down follows mode pins
// - Override one: power-down follows register bits
// - Result appears ten sample clocks after sampling
// - DDR pair: even bit then odd bit
// - Multiplexed output only with CMOS interface
// - Low output supply: capture with delayed sample clock
// - Mode pin code table, all high is mux
// - Init bit restores defaults and self-clears
// - Serial word: 8-bit address, 8-bit data
`default_nettype none
package acm_pkg;
	// ==========================================
	// Serial register map of the converter
	localparam logic [7:0] ACM_SREG_INIT = 8'h00;
	localparam logic [7:0] ACM_SREG_PD = 8'h01;
	localparam logic [7:0] ACM_SREG_CFG = 8'h02;
	localparam int ACM_INIT_BIT = 0;
	localparam int ACM_PIN_PRIORITY_OVERRIDE_BIT = 3;
	localparam int ACM_GAIN_BIT = 0;
	localparam int ACM_EXTREF_BIT = 1;
	localparam int ACM_CMOS_BIT = 2;
	localparam int ACM_SBIN_BIT = 3;
	localparam logic [2:0] ACM_PD_RST = 3'h0;
	localparam logic [3:0] ACM_CFG_RST = 4'h0;
	localparam int ACM_WORD_BITS = 16;
	// ==========================================
	// Mode pin codes {mode_pin_1, mode_pin_2, mode_pin_3}
	localparam logic [2:0] ACM_CODE_A_BUF_OFF = 3'h1;
	localparam logic [2:0] ACM_CODE_B_BUF_OFF = 3'h2;
	localparam logic [2:0] ACM_CODE_AB_BUF_OFF = 3'h3;
	localparam logic [2:0] ACM_CODE_AB_PD = 3'h4;
	localparam logic [2:0] ACM_CODE_A_STBY = 3'h5;
	localparam logic [2:0] ACM_CODE_B_STBY = 3'h6;
	localparam logic [2:0] ACM_CODE_MUX = 3'h7;
	// ==========================================
	// Timing
	localparam int ACM_CLK_MHZ = 200;
	localparam int ACM_LATENCY = 10;
	localparam int ACM_RST_PULSE_NS = 10;
	localparam int ACM_RST_PULSE_CYC = (ACM_RST_PULSE_NS * ACM_CLK_MHZ + 999) / 1000 + 1;
	localparam int ACM_SEN_SETUP_NS = 25;
	localparam int ACM_SEN_SETUP_CYC = (ACM_SEN_SETUP_NS * ACM_CLK_MHZ + 999) / 1000;
	localparam int ACM_SCLK_MAX_MHZ = 20;
	localparam int ACM_SCLK_HALF_CYC = (ACM_CLK_MHZ + 2 * ACM_SCLK_MAX_MHZ - 1) / (2 * ACM_SCLK_MAX_MHZ);
	localparam int ACM_PIN_HOLD_CYC = 64;
	// ==========================================
	// Host APB map
	localparam logic [7:0] ACM_A_CTRL = 8'h00;
	localparam logic [7:0] ACM_A_PINS = 8'h04;
	localparam logic [7:0] ACM_A_WRITE = 8'h08;
	localparam logic [7:0] ACM_A_STATUS = 8'h0C;
	typedef enum logic [1:0] {ACM_MODE_SERIAL, ACM_MODE_MIXED, ACM_MODE_PIN} acm_mode_e;
endpackage
`default_nettype wire

// File: tb_adc_config_mode_select.sv
// Purpose: Drives host over APB and checks the converter end
// Assumes: Short pin-mode hold of 16 cycles
// Notes: Samples frozen except for the latency test
`default_nettype none
module tb_adc_config_mode_select;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, strobe, frz, e, oa, ob, ph, pm, g, x, c, s;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [11:0] sa, sb, da, db, cnt, w;
	logic [2:0] code;
	logic [11:0] h[$];
	int fail_count, tests_run;
	// Rows: mode pins, power-down register, effective code
	localparam logic [13:0] ROWS [7] = '{14'h2815, 14'h2852, 14'h3864, 14'h0000, 14'h0801, 14'h301E, 14'h187F};
	acm_link_if link ();
	acm_host acm_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	acm_device #(.PIN_HOLD(16)) acm_device_inst (.pclk(pclk), .presetn(presetn), .link(link),
		.sample_strobe(strobe), .sample_a(sa), .sample_b(sb), .dout_a(da), .dout_b(db), .dout_oe_a(oa),
		.dout_oe_b(ob), .ddr_phase(ph), .pin_mode(pm), .cfg_gain(g), .cfg_extref(x), .cfg_cmos(c),
		.cfg_sbin(s), .cfg_code(code));
	acm_link_sva acm_link_sva_inst (.pclk(pclk), .presetn(presetn), .reset_pin(link.reset_pin),
		.serial_enable(link.serial_enable), .serial_clock(link.serial_clock),
		.config_serial_input(link.config_serial_input));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cnt <= cnt + 12'h001;
		sa <= frz ? 12'hA5C : cnt;
		sb <= frz ? 12'h5A3 : ~cnt;
		if (strobe)
			h.push_back(sa);
	end
	// ==========================================
	// Shared tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, got, exp);
		end
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			fail_count++;
			give_verdict();
		end
	endtask
	// Polls busy; a stuck link would otherwise hang the run
	task automatic idle;
		int n;
		n = 0;
		do begin
			apb(1'b0, acm_pkg::ACM_A_STATUS, 32'h0);
			n++;
		end while (r[0] !== 1'b0 && n < 100);
		if (n >= 100) begin
			fail_count++;
			give_verdict();
		end
		repeat (6) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic sw(input logic [15:0] wd);
		apb(1'b1, acm_pkg::ACM_A_WRITE, {16'h0000, wd});
		idle();
	endtask
	function automatic logic [11:0] pick(input logic [11:0] v, input logic p);
		pick = 12'h000;
		for (int j = 0; j < 6; j++)
			pick[j] = v[2 * j + p];
	endfunction
	initial begin
		repeat (100000) @(posedge pclk);
		fail_count++;
		give_verdict();
	end
	// ==========================================
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, strobe, e} = 6'h00;
		{paddr, pwdata, cnt, sa, sb} = '0;
		frz = 1'b1;
		fail_count = 0;
		tests_run = 0;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chk({pm, link.reset_pin, link.serial_enable}, 3'h1);
		chk(prdata, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		strobe <= 1'b1;
		$display("reset test done");
		apb(1'b1, acm_pkg::ACM_A_CTRL, 32'h1);
		idle();
		foreach (ROWS[i]) begin
			apb(1'b1, acm_pkg::ACM_A_PINS, {25'h0, 4'hF, ROWS[i][13:11]});
			sw({acm_pkg::ACM_SREG_PD, ROWS[i][10:3]});
			chk(code, ROWS[i][2:0]);
		end
		chk({s, c, x, g}, 4'h0);
		$display("override rows done");
		sw({acm_pkg::ACM_SREG_CFG, 8'h0B});
		chk({s, c, x, g}, 4'hB);
		sw({8'h55, 8'hFF});
		chk({s, c, x, g}, 4'hB);
		sw({acm_pkg::ACM_SREG_INIT, 8'h01});
		chk({s, c, x, g}, 4'h0);
		chk(code, 3'h3);
		apb(1'b0, 8'h40, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, e}, 32'h1);
		// Serial-only scheme: pins grounded, init pulse, reset pin back low
		apb(1'b1, acm_pkg::ACM_A_CTRL, 32'h0);
		idle();
		chk({link.mode_pin_1, link.mode_pin_2, link.mode_pin_3}, 3'h0);
		chk(code, 3'h0);
		chk(link.reset_pin, 1'b0);
		$display("serial tests done");
		apb(1'b1, acm_pkg::ACM_A_CTRL, 32'h2);
		repeat (30) @(posedge pclk);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, acm_pkg::ACM_A_PINS, {25'h0, i[1:0], i[1:0], 3'h0});
			repeat (16) @(posedge pclk);
			@(negedge pclk);
			w = (i[0] ^ i[1]) ? 12'h25C : 12'hA5C;
			chk(pm, 1'b1);
			chk({g, x}, {i[1], i[0] ^ i[1]});
			chk({c, s}, {i[1], i[0] ^ i[1]});
			chk(da, i[1] ? w : pick(w, ph));
		end
		apb(1'b1, acm_pkg::ACM_A_PINS, 32'h7F);
		repeat (16) @(posedge pclk);
		@(negedge pclk);
		chk(da, ph ? 12'h5A3 : 12'hA5C);
		chk(db, 12'h000);
		apb(1'b1, acm_pkg::ACM_A_PINS, 32'h78);
		frz <= 1'b0;
		repeat (20) @(posedge pclk);
		// Outputs taken on the sample clock, not an output clock
		@(negedge pclk);
		w = h[h.size() - 11];
		chk(da, w);
		w = ~w;
		chk(db, w);
		chk({oa, ob}, 2'h3);
		$display("pin tests done");
		give_verdict();
	end
endmodule
`default_nettype wire
